/* File: rtl/lesa_core.sv */
// link event status, acknowledge and interrupt block with apb register slave
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module lesa_core
    import lesa_pkg::*;
#(
    parameter int SUBGAP_CYC = LESA_SUBGAP_CYC,
    parameter int ARBITRATION_GAP_FLAG_CYC = LESA_ARBITRATION_GAP_FLAG_CYC,
    parameter int TIMER_W    = LESA_TIMER_W
) (
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,

    // apb slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,

    // link side events and levels
    input  wire lesa_event_type link_events,
    input  wire logic           bus_idle,
    input  wire logic           self_id_done,

    // outputs to link logic and host
    output logic                flush_async_queues,
    output logic                node_id_valid,
    output logic                irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [31:0]        status_ff;
    logic [31:0]        nxt_status;
    logic [31:0]        link_event_enable_ff;
    logic               timer_run_ff;
    logic               timer_continuous_mode_ff;
    logic [TIMER_W-1:0] reload_ff;
    logic [TIMER_W-1:0] count_ff;
    logic               timer_expired;
    logic [15:0]        idle_cnt_ff;
    logic               subaction_gap_flag_hit;
    logic               arbitration_gap_flag_hit;
    logic [31:0]        set_vec;
    logic [31:0]        clr_vec;
    logic               access;
    logic               wr_en;
    logic               known_addr;
    logic [31:0]        rd_value;
    logic [31:0]        prdata_ff;
    logic               pready_ff;
    logic               pslverr_ff;
    logic               flush_ff;
    logic               node_valid_ff;
    logic               irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr[11:2] == off[11:2]);
    endfunction

    function automatic logic [15:0] to16(input int value);
        to16 = value[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb access decode
    assign access = psel & penable & pready_ff;
    assign wr_en  = access & pwrite;

    // address map check
    always_comb begin
        known_addr = 1'b0;
        if (hit(paddr, LESA_CTRL_OFF) || hit(paddr, LESA_RELOAD_OFF) ||
            hit(paddr, LESA_STATUS_OFF) || hit(paddr, LESA_ENABLE_OFF) ||
            hit(paddr, LESA_CLEAR_OFF) || hit(paddr, LESA_NODE_OFF)) begin
            known_addr = 1'b1;
        end
    end

    // read mux
    always_comb begin
        rd_value = 32'h00000000;
        if (hit(paddr, LESA_CTRL_OFF)) begin
            rd_value[LESA_RUN_BIT]  = timer_run_ff;
            rd_value[LESA_CONT_BIT] = timer_continuous_mode_ff;
        end else if (hit(paddr, LESA_RELOAD_OFF)) begin
            rd_value[TIMER_W-1:0] = count_ff;
        end else if (hit(paddr, LESA_STATUS_OFF)) begin
            rd_value = status_ff;
        end else if (hit(paddr, LESA_ENABLE_OFF)) begin
            rd_value = link_event_enable_ff;
        end else if (hit(paddr, LESA_NODE_OFF)) begin
            rd_value[0] = node_valid_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            if (psel & penable & ~pready_ff) begin
                pslverr_ff <= ~known_addr;
                prdata_ff  <= pwrite ? 32'h00000000 : rd_value;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable register, same layout as status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_event_enable_ff <= LESA_ENABLE_RST;
        end else if (wr_en && hit(paddr, LESA_ENABLE_OFF)) begin
            link_event_enable_ff <= pwdata & LESA_STATUS_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer control and reload value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_continuous_mode_ff <= 1'b0;
            reload_ff                <= LESA_RELOAD_RST[TIMER_W-1:0];
        end else begin
            if (wr_en && hit(paddr, LESA_CTRL_OFF)) begin
                timer_continuous_mode_ff <= pwdata[LESA_CONT_BIT];
            end
            if (wr_en && hit(paddr, LESA_RELOAD_OFF)) begin
                reload_ff <= pwdata[TIMER_W-1:0];
            end
        end
    end

    // expiry when a running count stands at zero
    assign timer_expired = timer_run_ff & (count_ff == '0);

    // countdown timer, one shot or continuous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_run_ff <= 1'b0;
            count_ff     <= '0;
        end else if (wr_en && hit(paddr, LESA_CTRL_OFF)) begin
            timer_run_ff <= pwdata[LESA_RUN_BIT];
            count_ff     <= reload_ff;
        end else if (wr_en && hit(paddr, LESA_RELOAD_OFF)) begin
            count_ff <= pwdata[TIMER_W-1:0];
        end else if (timer_expired) begin
            count_ff     <= reload_ff;
            timer_run_ff <= timer_continuous_mode_ff;
        end else if (timer_run_ff) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus idle counter, saturates past the longer gap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_ff <= 16'h0000;
        end else if (!bus_idle) begin
            idle_cnt_ff <= 16'h0000;
        end else if (idle_cnt_ff != to16(ARBITRATION_GAP_FLAG_CYC)) begin
            idle_cnt_ff <= idle_cnt_ff + 16'h0001;
        end
    end

    // gap events fire once per idle stretch
    assign subaction_gap_flag_hit   = bus_idle & (idle_cnt_ff == to16(SUBGAP_CYC - 1));
    assign arbitration_gap_flag_hit = bus_idle & (idle_cnt_ff == to16(ARBITRATION_GAP_FLAG_CYC - 1));

    ////////////////////////////////////////////////////////////////////////
    // event set vector
    always_comb begin
        set_vec                   = 32'h00000000;
        set_vec[LESA_TIMER_BIT]   = timer_expired;
        set_vec[LESA_COMMAND_RESET_FLAG_BIT]  = link_events.reset_start_write;
        set_vec[LESA_SUBGAP_BIT]  = subaction_gap_flag_hit;
        set_vec[LESA_ARBITRATION_GAP_FLAG_BIT]  = arbitration_gap_flag_hit;
        set_vec[LESA_PHYINT_BIT]  = link_events.phy_int;
        set_vec[LESA_PHYREG_BIT]  = link_events.phy_reg_rx;
        set_vec[LESA_BUSRST_BIT]  = link_events.bus_reset;
        set_vec[LESA_ISOBAD_BIT]  = link_events.iso_stuck;
        set_vec[LESA_ASYBAD_BIT]  = link_events.async_stuck;
        set_vec[LESA_BUSYACK_BIT] = link_events.busy_ack_sent;
        set_vec[LESA_HDRERR_BIT]  = link_events.header_err;
    end

    // clear vector from status or clear register writes
    always_comb begin
        clr_vec = 32'h00000000;
        if (wr_en && (hit(paddr, LESA_STATUS_OFF) || hit(paddr, LESA_CLEAR_OFF))) begin
            clr_vec = pwdata & LESA_STATUS_MASK;
        end
    end

    // ones clear set flags, zeros leave them, new events win
    assign nxt_status = ((status_ff & ~clr_vec) | set_vec) & LESA_STATUS_MASK;

    ////////////////////////////////////////////////////////////////////////
    // sticky status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= LESA_STATUS_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus reset side effects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_ff      <= 1'b0;
            node_valid_ff <= 1'b0;
        end else begin
            flush_ff <= link_events.bus_reset;
            if (link_events.bus_reset) begin
                node_valid_ff <= 1'b0;
            end else if (self_id_done) begin
                node_valid_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_status & link_event_enable_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output drive
    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign flush_async_queues = flush_ff;
    assign node_id_valid      = node_valid_ff;
    assign irq                = irq_ff;

endmodule

/* File: rtl/lesa_pkg.sv */
// constants and types for the link event status and acknowledge block
//
// How it works
// - link and phy conditions latch into status flags that may raise an interrupt
// - enable register mirrors status layout, each enable bit gates its flag
// - writing one to a set flag clears it, acknowledging the interrupt
// - writing one to a clear flag, or writing zero, changes nothing
// - timer expiry sets bit 20 when countdown reaches zero
// - continuous mode selects one expiry or repeated expiries
// - bus write to reset-start register sets command reset flag, bit 18
// - bus idle for a subaction gap sets bit 17
// - bus idle for an arbitration reset gap sets bit 16
// - bus reset flushes async queues and clears node identity valid
package lesa_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [11:0] LESA_CTRL_OFF   = 12'h000;
    localparam logic [11:0] LESA_RELOAD_OFF = 12'h004;
    localparam logic [11:0] LESA_STATUS_OFF = 12'h008;
    localparam logic [11:0] LESA_ENABLE_OFF = 12'h00C;
    localparam logic [11:0] LESA_CLEAR_OFF  = 12'h010;
    localparam logic [11:0] LESA_NODE_OFF   = 12'h014;

    ////////////////////////////////////////////////////////////////////////
    // status bit positions
    localparam int LESA_TIMER_BIT   = 20;
    localparam int LESA_COMMAND_RESET_FLAG_BIT  = 18;
    localparam int LESA_SUBGAP_BIT  = 17;
    localparam int LESA_ARBITRATION_GAP_FLAG_BIT  = 16;
    localparam int LESA_PHYINT_BIT  = 15;
    localparam int LESA_PHYREG_BIT  = 14;
    localparam int LESA_BUSRST_BIT  = 13;
    localparam int LESA_ISOBAD_BIT  = 10;
    localparam int LESA_ASYBAD_BIT  = 9;
    localparam int LESA_BUSYACK_BIT = 8;
    localparam int LESA_HDRERR_BIT  = 7;

    // control bit positions
    localparam int LESA_RUN_BIT  = 0;
    localparam int LESA_CONT_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values and widths
    localparam logic [31:0] LESA_STATUS_RST = 32'h00000000;
    localparam logic [31:0] LESA_ENABLE_RST = 32'h00000000;
    localparam logic [31:0] LESA_STATUS_MASK = 32'h0017E780;
    localparam int          LESA_TIMER_W    = 24;
    localparam logic [23:0] LESA_RELOAD_RST = 24'h000000;

    ////////////////////////////////////////////////////////////////////////
    // timing: clock and idle gap durations
    localparam int LESA_CLK_MHZ     = 250;
    localparam int LESA_SUBGAP_NS   = 10000;
    localparam int LESA_ARBITRATION_GAP_FLAG_NS   = 20000;
    localparam int LESA_SUBGAP_CYC  = (LESA_SUBGAP_NS * LESA_CLK_MHZ + 999) / 1000;
    localparam int LESA_ARBITRATION_GAP_FLAG_CYC  = (LESA_ARBITRATION_GAP_FLAG_NS * LESA_CLK_MHZ + 999) / 1000;

    ////////////////////////////////////////////////////////////////////////
    // event pulses from the link and phy logic
    typedef struct packed {
        logic phy_int;
        logic phy_reg_rx;
        logic bus_reset;
        logic iso_stuck;
        logic async_stuck;
        logic busy_ack_sent;
        logic header_err;
        logic reset_start_write;
    } lesa_event_type;

endpackage

/* File: tb/lesa_assertions.sv */
// concurrent checks on the ports of the link event status block
`timescale 1ns/10ps
module lesa_assertions
    import lesa_pkg::*;
(
    // clock and reset
    input wire logic           pclk,
    input wire logic           presetn,
    // apb slave
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [11:0]    paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    // link side
    input wire lesa_event_type link_events,
    input wire logic           bus_idle,
    input wire logic           self_id_done,
    input wire logic           flush_async_queues,
    input wire logic           node_id_valid,
    input wire logic           irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // setup then access phase of one apb transfer
    sequence s_req;
        psel && !penable ##1 psel && penable;
    endsequence
    // bus reset pulse seen at the link side
    sequence s_busrst;
        link_events.bus_reset;
    endsequence

    property p_ready_slot; s_req |=> pready; endproperty
    property p_ready_qual; pready |-> psel && penable; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_qual; pslverr |-> pready; endproperty
    property p_flush; s_busrst |=> flush_async_queues; endproperty
    property p_node_clr; s_busrst |=> !node_id_valid; endproperty
    property p_irq_ack; $fell(irq) |-> $past(psel && penable && pready && pwrite, 1); endproperty
    property p_node_set; $rose(node_id_valid) |-> $past(self_id_done); endproperty

    a_ready_slot: assert property (p_ready_slot) else $error("pready late");
    a_ready_qual: assert property (p_ready_qual) else $error("pready outside access");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    a_err_qual: assert property (p_err_qual) else $error("pslverr without pready");
    a_flush: assert property (p_flush) else $error("no queue flush after bus reset");
    a_node_clr: assert property (p_node_clr) else $error("node valid kept over bus reset");
    a_irq_ack: assert property (p_irq_ack) else $error("irq fell without a write");
    a_node_set: assert property (p_node_set) else $error("node valid rose unprompted");
endmodule

bind lesa_core lesa_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_events(link_events), .bus_idle(bus_idle), .self_id_done(self_id_done),
    .flush_async_queues(flush_async_queues), .node_id_valid(node_id_valid), .irq(irq));

/* File: tb/link_event_status_ack_bench.sv */
// self-checking bench for the link event status block
`timescale 1ns/10ps
module link_event_status_ack_bench import lesa_pkg::*;;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd_data;
    lesa_event_type link_events;
    logic           bus_idle, self_id_done, flush_async_queues, node_id_valid, irq;
    int             err_count, checks, cycles;

    lesa_core #(.SUBGAP_CYC(5), .ARBITRATION_GAP_FLAG_CYC(9)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_events(link_events), .bus_idle(bus_idle),
        .self_id_done(self_id_done), .flush_async_queues(flush_async_queues),
        .node_id_valid(node_id_valid), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task conclude;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) chk("pready", 32'h1, {31'h0, pready});
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input string nm, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd_data);
    endtask
    task pulse(input logic [7:0] v);
        link_events <= lesa_event_type'(v);
        @(posedge pclk);
        link_events <= '0;
        @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_reset;
        rd(LESA_STATUS_OFF, "status", LESA_STATUS_RST);
        rd(LESA_ENABLE_OFF, "enable", LESA_ENABLE_RST);
        apb(1'b0, 12'h0F0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rd_err});
    endtask
    task t_command_reset_flag;
        pulse(8'h01);
        rd(LESA_STATUS_OFF, "cmd flag", 32'h00040000);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, LESA_ENABLE_OFF, 32'h00040000);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, LESA_STATUS_OFF, 32'h00020000);
        rd(LESA_STATUS_OFF, "no effect", 32'h00040000);
        apb(1'b1, LESA_STATUS_OFF, 32'h00040000);
        rd(LESA_STATUS_OFF, "acked", 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        apb(1'b1, LESA_ENABLE_OFF, 32'h0);
    endtask
    task t_gaps;
        bus_idle <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(LESA_STATUS_OFF, "subaction gap", 32'h00020000);
        repeat (6) @(posedge pclk);
        rd(LESA_STATUS_OFF, "arb gap", 32'h00030000);
        bus_idle <= 1'b0;
        apb(1'b1, LESA_CLEAR_OFF, 32'h00030000);
        rd(LESA_STATUS_OFF, "gaps cleared", 32'h0);
    endtask
    task t_timer;
        apb(1'b1, LESA_RELOAD_OFF, 32'h3);
        apb(1'b1, LESA_CTRL_OFF, 32'h1);
        repeat (8) @(posedge pclk);
        rd(LESA_STATUS_OFF, "timer", 32'h00100000);
        apb(1'b1, LESA_STATUS_OFF, 32'h00100000);
        repeat (12) @(posedge pclk);
        rd(LESA_STATUS_OFF, "one shot", 32'h0);
        apb(1'b1, LESA_CTRL_OFF, 32'h3);
        repeat (8) @(posedge pclk);
        rd(LESA_STATUS_OFF, "periodic", 32'h00100000);
        apb(1'b1, LESA_STATUS_OFF, 32'h00100000);
        repeat (8) @(posedge pclk);
        rd(LESA_STATUS_OFF, "repeat", 32'h00100000);
        apb(1'b1, LESA_CTRL_OFF, 32'h0);
        apb(1'b1, LESA_STATUS_OFF, 32'h00100000);
    endtask
    task t_busrst;
        self_id_done <= 1'b1;
        @(posedge pclk);
        self_id_done <= 1'b0;
        @(posedge pclk);
        rd(LESA_NODE_OFF, "node valid", 32'h1);
        link_events <= lesa_event_type'(8'h20);
        @(posedge pclk);
        link_events <= '0;
        #1;
        chk("flush", 32'h1, {31'h0, flush_async_queues});
        @(posedge pclk);
        rd(LESA_NODE_OFF, "node cleared", 32'h0);
        rd(LESA_STATUS_OFF, "bus reset flag", 32'h00002000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        link_events = '0; bus_idle = 1'b0; self_id_done = 1'b0;
        err_count = 0; checks = 0; cycles = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_command_reset_flag;
        t_gaps;
        t_timer;
        t_busrst;
        conclude();
    end
endmodule
